// ---- design/eaawc_map.svh ----
// register map, field positions, reset values of the area access / wait control
// assumes a 32-bit avalon-mm slave with byte addresses in 4 bits
`ifndef EAAWC_MAP_SVH
`define EAAWC_MAP_SVH

// ----------------------------------------
// byte offsets
// ----------------------------------------
`define EAAWC_ASC_OFS 4'h0
`define EAAWC_WCC_OFS 4'h4
`define EAAWC_STAT_OFS 4'h8

// ----------------------------------------
// field positions
// ----------------------------------------
`define EAAWC_AST_MSB 15
`define EAAWC_AST_LSB 8
`define EAAWC_W1_MSB 6
`define EAAWC_W1_LSB 4
`define EAAWC_W0_MSB 2
`define EAAWC_W0_LSB 0
`define EAAWC_ST_STATE_MSB 2
`define EAAWC_ST_STATE_LSB 0
`define EAAWC_ST_AREA_MSB 6
`define EAAWC_ST_AREA_LSB 4
`define EAAWC_ST_BUSY 8
`define EAAWC_ST_THREE 9

// ----------------------------------------
// reset values and counts
// ----------------------------------------
`define EAAWC_AST_RST 8'hff
`define EAAWC_WAIT_RST 3'h7
`define EAAWC_WAIT_NONE 3'h0
`define EAAWC_WAIT_STEP 3'h1

`endif

// ---- design/eaawc_pkg.sv ----
// types shared by the area access / wait control block
// assumes nothing of its surroundings
package eaawc_pkg;

	// bus cycle phases: t1, t2, program waits, t3
	typedef enum logic [2:0] {
		EAAWC_IDLE,
		EAAWC_T1,
		EAAWC_T2,
		EAAWC_TW,
		EAAWC_T3
	} eaawc_state_t;

endpackage : eaawc_pkg

// ---- design/eaawc_seq.sv ----
// external bus cycle sequencer: 2-state or 3-state cycles with program waits
// assumes start only while idle and wait_count valid with start
`timescale 1ns/10ps
`include "eaawc_map.svh"

module eaawc_seq (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// cycle request
	input wire logic start,
	input wire logic three_state,
	input wire logic [2:0] wait_count,
	// cycle progress
	output eaawc_pkg::eaawc_state_t state,
	output logic cyc_three,
	output logic [2:0] wait_left
);

	// ----------------------------------------
	// cycle type held per cycle, wait count loaded at start and counted down in waits
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cyc_three <= 1'b1;
		end else if (start && state == eaawc_pkg::EAAWC_IDLE) begin
			cyc_three <= three_state;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wait_left <= `EAAWC_WAIT_NONE;
		end else if (start && state == eaawc_pkg::EAAWC_IDLE) begin
			wait_left <= three_state ? wait_count : `EAAWC_WAIT_NONE;
		end else if (state == eaawc_pkg::EAAWC_TW) begin
			wait_left <= wait_left - `EAAWC_WAIT_STEP;
		end
	end

	// ----------------------------------------
	// phase sequence
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state <= eaawc_pkg::EAAWC_IDLE;
		end else begin
			case (state)
				eaawc_pkg::EAAWC_IDLE: begin
					if (start) begin
						state <= eaawc_pkg::EAAWC_T1;
					end
				end
				eaawc_pkg::EAAWC_T1: begin
					state <= eaawc_pkg::EAAWC_T2;
				end
				eaawc_pkg::EAAWC_T2: begin
					if (!cyc_three) begin
						state <= eaawc_pkg::EAAWC_IDLE;
					end else if (wait_left != `EAAWC_WAIT_NONE) begin
						state <= eaawc_pkg::EAAWC_TW;
					end else begin
						state <= eaawc_pkg::EAAWC_T3;
					end
				end
				eaawc_pkg::EAAWC_TW: begin
					if (wait_left == `EAAWC_WAIT_STEP) begin
						state <= eaawc_pkg::EAAWC_T3;
					end
				end
				eaawc_pkg::EAAWC_T3: begin
					state <= eaawc_pkg::EAAWC_IDLE;
				end
				default: begin
					state <= eaawc_pkg::EAAWC_IDLE;
				end
			endcase
		end
	end

endmodule : eaawc_seq

// ---- design/eaawc_ctrl.sv ----
// area access state and wait control: registers, bus cycle launch, area strobes
// assumes an avalon-mm master on clk and one external access requester
//
// The implementer's own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/10ps
`include "eaawc_map.svh"

// Summary of operation
// - area bit 0: two-state cycle, never any wait cycles
// - area bit 1: three-state cycle with wait insertion enabled
// - eight area select bits at 15..8, all reset to 1
// - bits 7..0 of access state register read zero, ignore writes
// - area 1 three-state: insert waits per bits 6..4, 0 to 7
// - area 0 three-state: insert waits per bits 2..0, 0 to 7
// - area 1 wait field resets to seven waits
// - area 0 wait field resets to seven waits
// - wait register bit 3 reads zero and ignores writes
module eaawc_ctrl #(
	parameter logic [2:0] AREA_HI_WAIT = 3'h0
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// avalon-mm register slave
	input wire logic [3:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	// external access request
	input wire logic acc_req,
	input wire logic [2:0] acc_area,
	input wire logic acc_write,
	output logic acc_ready,
	output logic acc_done,
	// external bus strobes
	output logic [7:0] ext_cs_n,
	output logic ext_rd_n,
	output logic ext_wr_n,
	output logic ext_wait_active
);

	// ----------------------------------------
	// register state
	// ----------------------------------------
	logic [7:0] area_three_state_select;
	logic [2:0] area1_wait_count;
	logic [2:0] area0_wait_count;
	logic bus_ack;
	logic wr_take;
	logic rd_load;
	logic [31:0] rd_mux;

	// ----------------------------------------
	// cycle state
	// ----------------------------------------
	eaawc_pkg::eaawc_state_t cyc_state;
	logic cyc_three;
	logic [2:0] cyc_wait_left;
	logic [2:0] cur_area;
	logic cur_write;
	logic start;
	logic sel_three;
	logic [2:0] sel_wait;
	logic busy;
	logic strobe_phase;

	// ----------------------------------------
	// avalon-mm handshake
	// ----------------------------------------
	// each request answers one cycle after it is raised
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			bus_ack <= 1'b0;
		end else begin
			bus_ack <= (read || write) && !bus_ack;
		end
	end

	assign waitrequest = (read || write) && !bus_ack;
	assign wr_take = write && bus_ack;
	assign rd_load = read && !bus_ack;

	// ----------------------------------------
	// access state control register
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			area_three_state_select <= `EAAWC_AST_RST;
		end else if (wr_take && address == `EAAWC_ASC_OFS && byteenable[1]) begin
			area_three_state_select <= writedata[`EAAWC_AST_MSB:`EAAWC_AST_LSB];
		end
	end

	// ----------------------------------------
	// area 0/1 wait count control register
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			area1_wait_count <= `EAAWC_WAIT_RST;
		end else if (wr_take && address == `EAAWC_WCC_OFS && byteenable[0]) begin
			area1_wait_count <= writedata[`EAAWC_W1_MSB:`EAAWC_W1_LSB];
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			area0_wait_count <= `EAAWC_WAIT_RST;
		end else if (wr_take && address == `EAAWC_WCC_OFS && byteenable[0]) begin
			area0_wait_count <= writedata[`EAAWC_W0_MSB:`EAAWC_W0_LSB];
		end
	end

	// ----------------------------------------
	// read data
	// ----------------------------------------
	always_comb begin
		rd_mux = 32'h0;
		case (address)
			`EAAWC_ASC_OFS: begin
				// low byte stays zero
				rd_mux[`EAAWC_AST_MSB:`EAAWC_AST_LSB] = area_three_state_select;
			end
			`EAAWC_WCC_OFS: begin
				// bit 3 stays zero
				rd_mux[`EAAWC_W1_MSB:`EAAWC_W1_LSB] = area1_wait_count;
				rd_mux[`EAAWC_W0_MSB:`EAAWC_W0_LSB] = area0_wait_count;
			end
			`EAAWC_STAT_OFS: begin
				rd_mux[`EAAWC_ST_STATE_MSB:`EAAWC_ST_STATE_LSB] = cyc_state;
				rd_mux[`EAAWC_ST_AREA_MSB:`EAAWC_ST_AREA_LSB] = cur_area;
				rd_mux[`EAAWC_ST_BUSY] = busy;
				rd_mux[`EAAWC_ST_THREE] = cyc_three;
			end
			default: begin
				rd_mux = 32'h0;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			readdata <= 32'h0;
		end else if (rd_load) begin
			readdata <= rd_mux;
		end
	end

	// ----------------------------------------
	// cycle launch and wait selection
	// ----------------------------------------
	assign acc_ready = (cyc_state == eaawc_pkg::EAAWC_IDLE);
	assign start = acc_req && acc_ready;
	assign sel_three = area_three_state_select[acc_area];

	always_comb begin
		sel_wait = `EAAWC_WAIT_NONE;
		if (sel_three) begin
			case (acc_area)
				3'h0: begin
					sel_wait = area0_wait_count;
				end
				3'h1: begin
					sel_wait = area1_wait_count;
				end
				default: begin
					sel_wait = AREA_HI_WAIT;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cur_area <= 3'h0;
			cur_write <= 1'b0;
		end else if (start) begin
			cur_area <= acc_area;
			cur_write <= acc_write;
		end
	end

	eaawc_seq u_seq (
		.clk(clk),
		.sys_rst(sys_rst),
		.start(start),
		.three_state(sel_three),
		.wait_count(sel_wait),
		.state(cyc_state),
		.cyc_three(cyc_three),
		.wait_left(cyc_wait_left)
	);

	// ----------------------------------------
	// external strobes
	// ----------------------------------------
	assign busy = (cyc_state != eaawc_pkg::EAAWC_IDLE);
	assign strobe_phase = (cyc_state == eaawc_pkg::EAAWC_T2) || (cyc_state == eaawc_pkg::EAAWC_TW) ||
		(cyc_state == eaawc_pkg::EAAWC_T3);
	assign ext_rd_n = !(strobe_phase && !cur_write);
	assign ext_wr_n = !(strobe_phase && cur_write);
	assign ext_wait_active = (cyc_state == eaawc_pkg::EAAWC_TW);
	assign acc_done = ((cyc_state == eaawc_pkg::EAAWC_T2) && !cyc_three) ||
		(cyc_state == eaawc_pkg::EAAWC_T3);

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_cs
			assign ext_cs_n[gi] = !(busy && cur_area == 3'(gi));
		end
	endgenerate

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	logic [3:0] tw_run;
	logic [2:0] launch_wait;
	logic [2:0] launch_area;
	logic launch_three;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tw_run <= 4'h0;
		end else if (start) begin
			tw_run <= 4'h0;
		end else if (cyc_state == eaawc_pkg::EAAWC_TW) begin
			tw_run <= tw_run + 4'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			launch_wait <= 3'h0;
			launch_area <= 3'h0;
			launch_three <= 1'b0;
		end else if (start) begin
			launch_wait <= sel_wait;
			launch_area <= acc_area;
			launch_three <= sel_three;
		end
	end

	two_state_nowait_a: assert property (
		(start && !sel_three) |=> (cyc_state == eaawc_pkg::EAAWC_T1) ##1
			(cyc_state == eaawc_pkg::EAAWC_T2 && acc_done) ##1 (cyc_state == eaawc_pkg::EAAWC_IDLE))
		else $error("two-state cycle not two states long");

	three_state_path_a: assert property (
		(cyc_state == eaawc_pkg::EAAWC_T2 && cyc_three) |=>
			(cyc_state == eaawc_pkg::EAAWC_TW || cyc_state == eaawc_pkg::EAAWC_T3))
		else $error("three-state cycle left t2 wrongly");

	select_reset_a: assert property (
		$fell(sys_rst) |-> area_three_state_select == `EAAWC_AST_RST)
		else $error("area select bits not all one after reset");

	select_write_a: assert property (
		(wr_take && address == `EAAWC_ASC_OFS && byteenable[1]) |=>
			area_three_state_select == $past(writedata[`EAAWC_AST_MSB:`EAAWC_AST_LSB]))
		else $error("area select write lost");

	asc_low_zero_a: assert property (
		(read && bus_ack && $past(address) == `EAAWC_ASC_OFS) |-> readdata == {16'h0, area_three_state_select, 8'h00})
		else $error("access state low byte not zero");

	area1_wait_a: assert property (
		(start && acc_area == 3'h1 && sel_three) |=> cyc_wait_left == $past(area1_wait_count))
		else $error("area 1 wait count not applied");

	area0_wait_a: assert property (
		(start && acc_area == 3'h0 && sel_three) |=> cyc_wait_left == $past(area0_wait_count))
		else $error("area 0 wait count not applied");

	wait_length_a: assert property (
		(cyc_state == eaawc_pkg::EAAWC_T3) |-> tw_run == {1'b0, launch_wait})
		else $error("wait states differ from programmed count");

	wait_reset_a: assert property (
		$fell(sys_rst) |-> (area1_wait_count == `EAAWC_WAIT_RST && area0_wait_count == `EAAWC_WAIT_RST))
		else $error("wait fields not seven after reset");

	reserved_bit3_a: assert property (
		(read && bus_ack && $past(address) == `EAAWC_WCC_OFS) |->
			readdata == {25'h0, area1_wait_count, 1'b0, area0_wait_count})
		else $error("reserved wait bit reads one");

	t3_entry_a: assert property (
		(cyc_state == eaawc_pkg::EAAWC_T3) |->
			($past(cyc_state) == eaawc_pkg::EAAWC_T2 || $past(cyc_state) == eaawc_pkg::EAAWC_TW))
		else $error("t3 not after t2 or a wait");

	wait_strobe_a: assert property (
		(cyc_state == eaawc_pkg::EAAWC_TW) |-> (strobe_phase && launch_three && ext_cs_n[launch_area] == 1'b0))
		else $error("strobes dropped during wait");

	answer_time_a: assert property (
		($rose(read) || $rose(write)) |-> waitrequest ##1 !waitrequest)
		else $error("bus answer not in one cycle");

	wait_write_a: assert property (
		(wr_take && address == `EAAWC_WCC_OFS && byteenable[0]) |=>
			(area1_wait_count == $past(writedata[`EAAWC_W1_MSB:`EAAWC_W1_LSB]) &&
			area0_wait_count == $past(writedata[`EAAWC_W0_MSB:`EAAWC_W0_LSB])))
		else $error("wait field write lost");

	two_state_quiet_a: assert property (
		(busy && !cyc_three) |-> (!ext_wait_active && cyc_wait_left == `EAAWC_WAIT_NONE))
		else $error("wait state inside a two-state cycle");

	three_state_wait_a: assert property (
		ext_wait_active |-> cyc_three)
		else $error("wait state outside a three-state cycle");

	hi_area_wait_a: assert property (
		(start && sel_three && acc_area > 3'h1) |=> cyc_wait_left == AREA_HI_WAIT)
		else $error("upper area wait count not applied");

	area_select_a: assert property (
		busy |-> (ext_cs_n == ~(8'h01 << cur_area)))
		else $error("area select not on the current area");

	idle_quiet_a: assert property (
		!busy |-> (&ext_cs_n && ext_rd_n && ext_wr_n && !ext_wait_active && !acc_done))
		else $error("strobes active while idle");

	strobe_excl_a: assert property (
		!(!ext_rd_n && !ext_wr_n))
		else $error("read and write strobes together");

	status_busy_a: assert property (
		(read && bus_ack && $past(address) == `EAAWC_STAT_OFS) |-> readdata[`EAAWC_ST_BUSY] == $past(busy))
		else $error("status busy bit stale");

	reset_idle_a: assert property (
		$fell(sys_rst) |-> (acc_ready && &ext_cs_n && readdata == 32'h0))
		else $error("outputs not idle after reset");

	two_state_cov: cover property (start && !sel_three);
	seven_wait_cov: cover property ((cyc_state == eaawc_pkg::EAAWC_T3) && tw_run == 4'h7);
	zero_wait_cov: cover property ($past(cyc_state) == eaawc_pkg::EAAWC_T2 &&
		cyc_state == eaawc_pkg::EAAWC_T3);
	reg_write_cov: cover property (wr_take && address == `EAAWC_WCC_OFS);
	wait_cycle_cov: cover property (ext_wait_active && cur_area == 3'h1);

endmodule : eaawc_ctrl

// ---- verif/eaawc_ext_model.sv ----
// external memory model: watches area selects and strobes, reports the last cycle
// assumes strobes from eaawc_ctrl on the same clk
`timescale 1ns/10ps

module eaawc_ext_model (
	// clock
	input wire logic clk,
	// external bus strobes
	input wire logic [7:0] ext_cs_n,
	input wire logic ext_rd_n,
	input wire logic ext_wr_n,
	input wire logic ext_wait_active,
	// measurements of the last finished cycle
	output logic [7:0] last_sel,
	output logic [4:0] last_len,
	output logic [3:0] last_waits,
	output logic [4:0] last_strobe,
	output logic last_write
);
	logic [7:0] sel = 8'h00;
	logic [4:0] len = 5'h00;
	logic [3:0] waits = 4'h0;
	logic [4:0] strobe = 5'h00;
	logic wr_seen = 1'b0;

	// count states while any area is selected, latch when released
	always @(posedge clk) begin
		if (ext_cs_n != 8'hff) begin
			sel <= ~ext_cs_n;
			len <= len + 5'h01;
			waits <= waits + {3'h0, ext_wait_active};
			strobe <= strobe + {4'h0, (!ext_rd_n || !ext_wr_n)};
			wr_seen <= wr_seen | !ext_wr_n;
		end else if (len != 5'h00) begin
			last_sel <= sel;
			last_len <= len;
			last_waits <= waits;
			last_strobe <= strobe;
			last_write <= wr_seen;
			len <= 5'h00;
			waits <= 4'h0;
			strobe <= 5'h00;
			wr_seen <= 1'b0;
		end
	end
endmodule : eaawc_ext_model

// ---- verif/eaawc_ctrl_bench.sv ----
// self-checking bench of eaawc_ctrl with an external memory model
// assumes the register map header and a 10 MHz clock
`timescale 1ns/10ps
`include "eaawc_map.svh"

module eaawc_ctrl_bench;
	typedef struct packed {
		logic [7:0] ast;
		logic [7:0] wc;
		logic [2:0] area;
		logic wr;
		logic [4:0] len;
		logic [3:0] waits;
	} eaawc_row_t;

	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [3:0] address = 4'h0;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [3:0] byteenable = 4'hf;
	logic [31:0] readdata;
	logic waitrequest;
	logic acc_req = 1'b0;
	logic [2:0] acc_area = 3'h0;
	logic acc_write = 1'b0;
	logic acc_ready, acc_done, ext_rd_n, ext_wr_n, ext_wait_active;
	logic [7:0] ext_cs_n, last_sel;
	logic [4:0] last_len, last_strobe;
	logic [3:0] last_waits;
	logic last_write;
	logic [31:0] rd;
	int miscompares = 0;
	int checks_done = 0;
	eaawc_row_t rows [10];

	always #50 clk = ~clk;

	eaawc_ctrl i_eaawc_ctrl (.clk(clk), .sys_rst(sys_rst), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
		.acc_req(acc_req), .acc_area(acc_area), .acc_write(acc_write), .acc_ready(acc_ready),
		.acc_done(acc_done), .ext_cs_n(ext_cs_n), .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n),
		.ext_wait_active(ext_wait_active));

	eaawc_ext_model i_eaawc_ext_model (.clk(clk), .ext_cs_n(ext_cs_n), .ext_rd_n(ext_rd_n),
		.ext_wr_n(ext_wr_n), .ext_wait_active(ext_wait_active), .last_sel(last_sel), .last_len(last_len),
		.last_waits(last_waits), .last_strobe(last_strobe), .last_write(last_write));

	// ----------------------------------------
	// report and bus tasks
	// ----------------------------------------
	task end_of_test;
		if (miscompares == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_of_test

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	// 0: waitrequest low, 1: acc_ready high, else acc_done high
	function automatic logic flag_of(input int sel);
		case (sel)
			0: return waitrequest === 1'b0;
			1: return acc_ready === 1'b1;
			default: return acc_done === 1'b1;
		endcase
	endfunction : flag_of

	task automatic wait_flag(input int sel, input string name);
		int n;
		n = 0;
		@(posedge clk);
		while (!flag_of(sel) && n < 30) begin
			@(posedge clk);
			n++;
		end
		if (n >= 30) begin
			miscompares++;
			$display("[FAIL] %s expected 1 seen timeout", name);
			end_of_test();
		end
	endtask : wait_flag

	task automatic bus_write(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
		address <= a;
		writedata <= d;
		byteenable <= be;
		write <= 1'b1;
		wait_flag(0, "waitrequest");
		write <= 1'b0;
		@(posedge clk);
	endtask : bus_write

	task automatic bus_read(input logic [3:0] a, output logic [31:0] d);
		address <= a;
		read <= 1'b1;
		wait_flag(0, "waitrequest");
		d = readdata;
		read <= 1'b0;
		@(posedge clk);
	endtask : bus_read

	task automatic ext_access(input logic [2:0] ar, input logic wr);
		acc_req <= 1'b1;
		acc_area <= ar;
		acc_write <= wr;
		wait_flag(1, "acc_ready");
		acc_req <= 1'b0;
		wait_flag(2, "acc_done");
		repeat (2) @(posedge clk);
	endtask : ext_access

	task automatic check_cycle(input logic [2:0] ar, input logic wr, input logic [4:0] len, input logic [3:0] w);
		check("area select", 32'h1 << ar, {24'h0, last_sel});
		check("cycle length", {27'h0, len}, {27'h0, last_len});
		check("wait states", {28'h0, w}, {28'h0, last_waits});
		check("strobe length", {27'h0, len} - 32'h1, {27'h0, last_strobe});
		check("direction", {31'h0, wr}, {31'h0, last_write});
	endtask : check_cycle

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		rows[0] = {8'hff, 8'h00, 3'h0, 1'b0, 5'd3, 4'd0};
		rows[1] = {8'hff, 8'h07, 3'h0, 1'b1, 5'd10, 4'd7};
		rows[2] = {8'hff, 8'h70, 3'h1, 1'b0, 5'd10, 4'd7};
		rows[3] = {8'hff, 8'h30, 3'h1, 1'b1, 5'd6, 4'd3};
		rows[4] = {8'hfe, 8'h77, 3'h0, 1'b0, 5'd2, 4'd0};
		rows[5] = {8'hfd, 8'h77, 3'h1, 1'b1, 5'd2, 4'd0};
		rows[6] = {8'h7f, 8'h77, 3'h7, 1'b0, 5'd2, 4'd0};
		rows[7] = {8'hff, 8'h77, 3'h5, 1'b1, 5'd3, 4'd0};
		rows[8] = {8'hff, 8'h25, 3'h0, 1'b0, 5'd8, 4'd5};
		rows[9] = {8'hff, 8'h25, 3'h1, 1'b1, 5'd5, 4'd2};
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		bus_read(`EAAWC_ASC_OFS, rd);
		check("select reset", 32'h0000ff00, rd);
		bus_read(`EAAWC_WCC_OFS, rd);
		check("wait reset", 32'h00000077, rd);
		ext_access(3'h1, 1'b0);
		check_cycle(3'h1, 1'b0, 5'd10, 4'd7);
		foreach (rows[i]) begin
			bus_write(`EAAWC_ASC_OFS, {16'h0, rows[i].ast, 8'h00}, 4'hf);
			bus_write(`EAAWC_WCC_OFS, {24'h0, rows[i].wc}, 4'hf);
			ext_access(rows[i].area, rows[i].wr);
			check_cycle(rows[i].area, rows[i].wr, rows[i].len, rows[i].waits);
		end
		bus_write(`EAAWC_ASC_OFS, 32'hffffffff, 4'hf);
		bus_read(`EAAWC_ASC_OFS, rd);
		check("select low byte", 32'h0000ff00, rd);
		bus_write(`EAAWC_WCC_OFS, 32'hffffffff, 4'hf);
		bus_read(`EAAWC_WCC_OFS, rd);
		check("wait bit 3", 32'h00000077, rd);
		bus_write(`EAAWC_ASC_OFS, 32'h00000000, 4'h1);
		bus_read(`EAAWC_ASC_OFS, rd);
		check("lane gating", 32'h0000ff00, rd);
		bus_read(4'hc, rd);
		check("unmapped read", 32'h0, rd);
		bus_write(`EAAWC_WCC_OFS, 32'h0, 4'hf);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		ext_access(3'h0, 1'b1);
		check_cycle(3'h0, 1'b1, 5'd10, 4'd7);
		bus_read(`EAAWC_WCC_OFS, rd);
		check("wait after reset", 32'h00000077, rd);
		bus_write(`EAAWC_STAT_OFS, 32'hffffffff, 4'hf);
		bus_read(`EAAWC_STAT_OFS, rd);
		check("status idle", 32'h00000200, rd);
		end_of_test();
	end
endmodule : eaawc_ctrl_bench
